// ### verilog/ald_pkg.sv
// package with opcodes, field positions and reset values for the accumulator-load decoder
package ald_pkg;
   localparam int ALD_IW = 10;
   localparam int ALD_DW = 4;
   localparam int ALD_XW = 4;
   localparam int ALD_DPW = 6;
   // opcode patterns
   localparam logic [5:0] ALD_MEM_HI = 6'h2C;
   localparam logic [9:0] ALD_OP_CLK = 10'h252;
   localparam logic [9:0] ALD_OP_PU_LO = 10'h257;
   localparam logic [9:0] ALD_OP_PU_HI = 10'h25E;
   // immediate field position
   localparam int ALD_IMM_LSB = 0;
   localparam int ALD_IMM_MSB = 3;
   localparam int ALD_CYCLES = 1;
   // reset values
   localparam logic [3:0] ALD_ACC_RST = 4'h0;
   localparam logic [3:0] ALD_X_RST = 4'h0;
   localparam logic [3:0] ALD_REG_RST = 4'h0;
   typedef enum logic [4:0] {
      ALD_K_NONE = 5'b00001,
      ALD_K_MEM = 5'b00010,
      ALD_K_CLK = 5'b00100,
      ALD_K_PULO = 5'b01000,
      ALD_K_PUHI = 5'b10000
   } ald_kind_t;
endpackage

// ### verilog/ald_data_mem.sv
// small data memory with registered read port
`timescale 1ns/100ps
module ald_data_mem
   import ald_pkg::*;
#(
   parameter int AW = 6,
   parameter int DW = 4
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
   end
endmodule // ald_data_mem

// ### verilog/ald_decode.sv
// accumulator-load instruction decoder with x pointer, control registers and data memory
`timescale 1ns/100ps
module ald_decode
   import ald_pkg::*;
#(
   parameter int DPW = ALD_DPW
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [ALD_IW-1:0] i_instr,
   input wire logic [DPW-1:0] i_data_pointer,
   input wire logic i_mem_we,
   input wire logic [DPW-1:0] i_mem_waddr,
   input wire logic [ALD_DW-1:0] i_mem_wdata,
   input wire logic i_clk_ctrl_we,
   input wire logic i_pu_lo_we,
   input wire logic i_pu_hi_we,
   input wire logic [ALD_DW-1:0] i_reg_wdata,
   input wire logic i_carry_in,
   output logic [ALD_DW-1:0] o_acc,
   output logic [ALD_XW-1:0] o_x_ptr,
   output logic [ALD_DW-1:0] o_clock_control_reg,
   output logic [ALD_DW-1:0] o_pullup_ctrl_lo,
   output logic [ALD_DW-1:0] o_pullup_ctrl_hi,
   output logic o_carry_flag,
   output logic o_skip,
   output logic o_done
);
   function automatic ald_kind_t decode(input logic v, input logic [ALD_IW-1:0] ins);
      if (!v) return ALD_K_NONE;
      else if (ins[9:4] == ALD_MEM_HI) return ALD_K_MEM;
      else if (ins == ALD_OP_CLK) return ALD_K_CLK;
      else if (ins == ALD_OP_PU_LO) return ALD_K_PULO;
      else if (ins == ALD_OP_PU_HI) return ALD_K_PUHI;
      else return ALD_K_NONE;
   endfunction

   // memory read is registered, so the address is presented from the pointer itself
   ald_kind_t kind_w;
   logic [ALD_DW-1:0] mem_rdata;
   logic [ALD_XW-1:0] imm_w;
   logic [ALD_DW-1:0] acc_d, acc_q, clk_q, pulo_q, puhi_q;
   logic [ALD_XW-1:0] x_d, x_q;
   logic cy_q, done_q, mem_pend_q;

   assign kind_w = decode(i_valid, i_instr);
   assign imm_w = i_instr[ALD_IMM_MSB:ALD_IMM_LSB];

   ald_data_mem #(.AW(DPW), .DW(ALD_DW)) u_mem (
      .i_clk(i_clk),
      .i_we(i_mem_we),
      .i_waddr(i_mem_waddr),
      .i_wdata(i_mem_wdata),
      .i_raddr(i_data_pointer),
      .o_rdata(mem_rdata)
   );

   // the memory word is ready in the register one cycle after the pointer; the fetch presents
   // the pointer a cycle ahead, so the load completes in the instruction cycle itself
   assign x_d = (kind_w == ALD_K_MEM) ? (x_q ^ imm_w) : x_q;
   assign acc_d = (kind_w == ALD_K_MEM) ? mem_rdata :
                  (kind_w == ALD_K_CLK) ? clk_q :
                  (kind_w == ALD_K_PULO) ? pulo_q :
                  (kind_w == ALD_K_PUHI) ? puhi_q : acc_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_q <= ALD_ACC_RST;
         x_q <= ALD_X_RST;
         done_q <= 1'b0;
         mem_pend_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         x_q <= x_d;
         done_q <= (kind_w != ALD_K_NONE);
         mem_pend_q <= (kind_w == ALD_K_MEM);
      end
   end

   // source registers change only on their own writes, never on a load
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_q <= ALD_REG_RST;
         pulo_q <= ALD_REG_RST;
         puhi_q <= ALD_REG_RST;
         cy_q <= 1'b0;
      end else begin
         if (i_clk_ctrl_we) clk_q <= i_reg_wdata;
         if (i_pu_lo_we) pulo_q <= i_reg_wdata;
         if (i_pu_hi_we) puhi_q <= i_reg_wdata;
         if (kind_w == ALD_K_NONE) cy_q <= i_carry_in;
      end
   end

   assign o_acc = acc_q;
   assign o_x_ptr = x_q;
   assign o_clock_control_reg = clk_q;
   assign o_pullup_ctrl_lo = pulo_q;
   assign o_pullup_ctrl_hi = puhi_q;
   assign o_carry_flag = cy_q;
   assign o_skip = 1'b0;
   assign o_done = done_q;

   a_mem_acc_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_MEM |=> acc_q == $past(mem_rdata)) else $error("memory load wrong");
   a_x_xor_imm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_MEM |=> x_q == ($past(x_q) ^ $past(imm_w))) else $error("x update wrong");
   a_x_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w != ALD_K_MEM |=> $stable(x_q)) else $error("x changed");
   a_clk_acc_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_CLK |=> acc_q == $past(clk_q)) else $error("clock ctrl load wrong");
   a_pulo_acc_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_PULO |=> acc_q == $past(pulo_q)) else $error("pullup lo load wrong");
   a_puhi_acc_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_PUHI |=> acc_q == $past(puhi_q)) else $error("pullup hi load wrong");
   a_carry_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w != ALD_K_NONE |=> $stable(o_carry_flag)) else $error("carry changed");
   a_src_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_CLK && !i_clk_ctrl_we |=> $stable(clk_q) && !o_skip) else $error("source changed");
   a_done_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w != ALD_K_NONE |=> o_done) else $error("done missing");

   // refused words raise no done pulse and leave the accumulator unchanged; the carry still follows its input
   a_done_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_NONE |=> !o_done) else $error("done on refused word");
   a_acc_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_NONE |=> $stable(acc_q)) else $error("accumulator changed");

   // the pull-up sources survive their own read
   a_pulo_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_PULO && !i_pu_lo_we |=> $stable(pulo_q)) else $error("pullup lo changed");
   a_puhi_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_PUHI && !i_pu_hi_we |=> $stable(puhi_q)) else $error("pullup hi changed");

   // carry only follows its input between loads
   a_carry_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_NONE |=> o_carry_flag == $past(i_carry_in)) else $error("carry not loaded");
   a_skip_never: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w != ALD_K_NONE |=> !o_skip) else $error("skip raised");

   // register write ports land one edge later
   a_clk_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_clk_ctrl_we |=> clk_q == $past(i_reg_wdata)) else $error("clock ctrl write lost");
   a_pulo_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_pu_lo_we |=> pulo_q == $past(i_reg_wdata)) else $error("pullup lo write lost");
   a_puhi_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_pu_hi_we |=> puhi_q == $past(i_reg_wdata)) else $error("pullup hi write lost");
   a_mem_pend: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kind_w == ALD_K_MEM |=> mem_pend_q) else $error("memory load not marked");

   c_mem: cover property (@(posedge i_clk) disable iff (!i_rst_n) kind_w == ALD_K_MEM);
   c_clk: cover property (@(posedge i_clk) disable iff (!i_rst_n) kind_w == ALD_K_CLK);
   c_pu: cover property (@(posedge i_clk) disable iff (!i_rst_n) kind_w == ALD_K_PULO ##1 kind_w == ALD_K_PUHI);
   c_mem_b2b: cover property (@(posedge i_clk) disable iff (!i_rst_n) mem_pend_q && kind_w == ALD_K_MEM);
endmodule // ald_decode

// ### testbench/ald_fetch_model.sv
// behavioural instruction fetch: presents a requested word one cycle later
`timescale 1ns/100ps
module ald_fetch_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [9:0] i_word,
   output logic o_valid,
   output logic [9:0] o_instr
);
   initial o_valid = 1'b0;
   initial o_instr = 10'h000;
   // idle cycles carry a changing word so stale opcodes never look valid
   // request is captured at the edge, before the bench moves it, and shown 1 ns later
   logic go_s;
   logic [9:0] word_s;
   always @(posedge i_clk) begin
      go_s = i_go;
      word_s = i_word;
      #1;
      o_valid = go_s;
      o_instr = go_s ? word_s : ~o_instr;
   end
endmodule // ald_fetch_model

// ### testbench/accumulator_load_decode_tb.sv
// self-checking bench for the accumulator-load decoder
`timescale 1ns/100ps
module accumulator_load_decode_tb;
   import ald_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, mem_we = 1'b0, carry_in = 1'b1, valid, carry, skip, done;
   logic clk_we = 1'b0, lo_we = 1'b0, hi_we = 1'b0;
   logic [9:0] word = 10'h000, instr;
   logic [5:0] dp = 6'h00, waddr = 6'h00;
   logic [3:0] wdata = 4'h0, reg_wdata = 4'h0, acc, x, cc, lo, hi;
   int fails = 0, checks = 0, cyc = 0;
   logic [9:0] rw [6] = '{10'h2c5, 10'h2cf, 10'h252, 10'h257, 10'h25e, 10'h2c0};
   logic [5:0] rp [6] = '{6'h03, 6'h07, 6'h00, 6'h00, 6'h00, 6'h01};
   logic [7:0] re [6] = '{8'h65, 8'haa, 8'haa, 8'h5a, 8'hca, 8'h4a};
   always #25 clk = ~clk;
   ald_fetch_model fetch (.i_clk(clk), .i_go(go), .i_word(word), .o_valid(valid), .o_instr(instr));
   ald_decode dut (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .i_instr(instr), .i_data_pointer(dp),
      .i_mem_we(mem_we), .i_mem_waddr(waddr), .i_mem_wdata(wdata), .i_clk_ctrl_we(clk_we),
      .i_pu_lo_we(lo_we), .i_pu_hi_we(hi_we), .i_reg_wdata(reg_wdata), .i_carry_in(carry_in),
      .o_acc(acc), .o_x_ptr(x), .o_clock_control_reg(cc), .o_pullup_ctrl_lo(lo), .o_pullup_ctrl_hi(hi),
      .o_carry_flag(carry), .o_skip(skip), .o_done(done));
   task chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      repeat (10) step;
      chk({acc, x, cc}, 12'h000);
      rst_n = 1'b1;
      $display("reset test done");
      for (int a = 0; a < 8; a++) begin
         mem_we = 1'b1;
         waddr = a[5:0];
         wdata = a[3:0] + 4'h3;
         step;
      end
      mem_we = 1'b0;
      clk_we = 1'b1;
      reg_wdata = 4'ha;
      step;
      clk_we = 1'b0;
      lo_we = 1'b1;
      reg_wdata = 4'h5;
      step;
      lo_we = 1'b0;
      hi_we = 1'b1;
      reg_wdata = 4'hc;
      step;
      hi_we = 1'b0;
      // each row: pointer leads by a cycle, carry input flips during the load
      for (int r = 0; r < 6; r++) begin
         dp = rp[r];
         go = 1'b1;
         word = rw[r];
         step;
         go = 1'b0;
         carry_in = 1'b0;
         step;
         #1;
         chk({acc, x, done, carry, skip, 1'b0}, {re[r], 4'hc});
         chk({cc, lo, hi}, 12'ha5c);
         carry_in = 1'b1;
         $display("row %0d test done", r);
      end
      go = 1'b1;
      word = 10'h253;
      step;
      go = 1'b0;
      step;
      #1;
      chk({acc, x, done, 3'b000}, 12'h4a0);
      $display("unknown opcode test done");
      go = 1'b1;
      word = 10'h257;
      step;
      word = 10'h25e;
      step;
      go = 1'b0;
      #1;
      chk({acc, done, 7'h00}, 12'h580);
      step;
      chk({acc, done, 7'h00}, 12'hc80);
      $display("back to back test done");
      final_report();
   end
endmodule // accumulator_load_decode_tb
